// ### rtl/dpa_acc_if.sv
// Link between the sequencer and one channel accumulator.
`timescale 1ns/1ps
interface dpa_acc_if;
  import dpa_pkg::*;
  logic              add;
  logic              clear;
  logic [PROD_W-1:0] product;
  logic [ACC_W-1:0]  acc;
  logic              sat;
  modport ctl (output add, output clear, output product, input acc, input sat);
  modport acc_side (input add, input clear, input product, output acc, output sat);
endinterface : dpa_acc_if

// ### rtl/dpa_accum.sv
// Saturating power accumulator for one channel.
`timescale 1ns/1ps
module dpa_accum
  import dpa_pkg::*;
(
  input  wire logic  i_clk_sys,
  input  wire logic  i_rst,
  dpa_acc_if.acc_side bus
);
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W:0]   sum;

  assign sum     = {1'b0, acc_r} + (ACC_W + 1)'(bus.product);
  assign bus.acc = acc_r;
  // Pulses when an addition lands on or beyond full scale.
  assign bus.sat = bus.add & (sum[ACC_W] | (&sum[ACC_W-1:0]));

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || bus.clear) begin
      acc_r <= '0;
    end else if (bus.add) begin
      acc_r <= sum[ACC_W] ? {ACC_W{1'b1}} : sum[ACC_W-1:0];
    end
  end
endmodule : dpa_accum

// ### rtl/dpa_pkg.sv
// Shared constants and types of the dual power accumulator.
package dpa_pkg;
  // ----------------------------------------------------------------
  // Clock and rates
  // ----------------------------------------------------------------
  localparam int CLK_HZ       = 40_000_000;
  localparam int BASE_RATE_HZ = 4;
  localparam int BASE_DIV_CYC = CLK_HZ / BASE_RATE_HZ;
  localparam logic [3:0] RATE_RST = 4'h0;
  localparam logic [3:0] RATE_MAX = 4'ha;

  // ----------------------------------------------------------------
  // Data widths
  // ----------------------------------------------------------------
  localparam int VOLT_W     = 14;
  localparam int ADC_I_W    = 13;
  localparam int CUR_W      = 16;
  localparam int PROD_W     = 30;
  localparam int ACC_W      = 56;
  localparam int CNT_W      = 24;
  localparam int GAIN_SHIFT = 3;
  localparam logic [ADC_I_W-1:0] HG_FULL = 13'h1fff;

  // ----------------------------------------------------------------
  // Serial bus commands and values
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_UPDATE  = 8'h00;
  localparam logic [7:0] CMD_CONTROL = 8'h01;
  localparam logic [7:0] CMD_ACC_CNT = 8'h02;
  localparam logic [7:0] CMD_PWR_1   = 8'h03;
  localparam logic [7:0] CMD_PWR_2   = 8'h04;
  localparam logic [7:0] CMD_VOLT_1  = 8'h07;
  localparam logic [7:0] CMD_VOLT_2  = 8'h08;
  localparam logic [7:0] CMD_RATE    = 8'h20;
  localparam logic [7:0] CMD_RST     = 8'h01;
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [7:0] NO_DATA     = 8'hff;
  localparam int         SAT_BIT     = 0;
  localparam logic [2:0] NB_CNT      = 3'h3;
  localparam logic [2:0] NB_ACC      = 3'h7;
  localparam logic [2:0] NB_VOLT     = 3'h2;
  localparam logic [3:0] BITS_BYTE   = 4'h8;

  typedef enum logic [1:0] {KIND_VOLT, KIND_HI, KIND_LO} dpa_kind_e;
endpackage : dpa_pkg

// ### rtl/dpa_sync.sv
// Two-flop synchroniser for levels from outside the clock domain.
`timescale 1ns/1ps
module dpa_sync #(
  parameter int           W      = 1,
  parameter logic [W-1:0] P_INIT = '0
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      meta_r <= P_INIT;
      o_q    <= P_INIT;
    end else begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end
endmodule : dpa_sync

// ### rtl/dpa_top.sv
// Dual power accumulator with serial bus target interface.
// Operation
// - Sequencer visits both channels, taking voltage and current samples unprompted.
// - Each period multiplies 16-bit current by 14-bit voltage into 30-bit product.
// - Every channel owns its own 56-bit accumulator of power products.
// - Accumulation rate is selectable from 4 to 4096 per second.
// - Snapshot command copies count and both accumulators into readable holding registers.
// - A full accumulator stays at its maximum instead of wrapping.
// - Voltage results are 14 bits; current converter results are 13 bits.
// - Two current conversions, high and low gain, form one 16-bit current.
// - High-gain result is weighted eight times finer than the low-gain result.
// - Unsaturated high-gain result is used, otherwise the low-gain result.
// - Serial bytes travel most significant bit first.
// - Command pointer starts at the configuration and status command.
// - Reads with an unsupported command return all ones.
// - Target address is latched once after reset and kept.
// - After power-up a rising edge on the address pin resets the device.
// - Single-byte read uses command write, repeated start, read, final not-acknowledge.
// - Single-byte write acknowledges address, command and data byte.
// - Command-only transfer acknowledges address and command, then stop.
// - Snapshot clears the sample count and both accumulators.
// - Snapshot leaves the saturation flag alone; only a host write or a reset, including the pin reset, clears it.
`timescale 1ns/1ps
module dpa_top
  import dpa_pkg::*;
#(
  parameter int P_BASE_DIV = BASE_DIV_CYC
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  input  wire logic              i_scl,
  input  wire logic              i_sda,
  output logic                   o_sda_o,
  output logic                   o_sda_oe,
  input  wire logic              i_addr_rst_pin,
  input  wire logic [6:0]        i_addr_code,
  output logic                   o_adc_start,
  output logic                   o_adc_chan,
  output dpa_kind_e              o_adc_kind,
  input  wire logic              i_adc_done,
  input  wire logic [VOLT_W-1:0] i_adc_data,
  output logic                   o_saturation_flag
);
  // ----------------------------------------------------------------
  // Reset, address latch and pin synchronisers
  // ----------------------------------------------------------------
  typedef enum {T_IDLE, T_ADDR, T_CMD, T_WDAT, T_ACK, T_RDAT, T_RACK, T_SKIP} dpa_bus_e;
  typedef enum {Q_IDLE, Q_CONV, Q_WAIT, Q_ADD} dpa_seq_e;

  logic       rst_int;
  logic       soft_rst_r;
  logic       addr_valid_r;
  logic [6:0] addr_r;
  logic [2:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       pin_s;
  logic       scl_q_r;
  logic       sda_q_r;
  logic       pin_q_r;

  assign rst_int = i_rst | soft_rst_r;
  assign scl_s   = pins_s[0];
  assign sda_s   = pins_s[1];
  assign pin_s   = pins_s[2];

  dpa_sync #(.W(3), .P_INIT(3'h7)) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_d       ({i_addr_rst_pin, i_sda, i_scl}),
    .o_q       (pins_s)
  );

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      pin_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
      pin_q_r <= pin_s;
    end
  end

  // The pin only counts as a reset once it has been seen low after power-up.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= addr_valid_r & pin_s & ~pin_q_r;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (rst_int) begin
      addr_valid_r <= 1'b0;
      addr_r       <= 7'h00;
    end else if (!addr_valid_r) begin
      addr_valid_r <= 1'b1;
      addr_r       <= i_addr_code;
    end
  end

  // ----------------------------------------------------------------
  // Registers written over the bus
  // ----------------------------------------------------------------
  logic       wr_p;
  logic       upd_p;
  logic [7:0] wdat_r;
  logic [7:0] cmd_r;
  logic [7:0] ctrl_r;
  logic [3:0] rate_r;
  logic       sat_flag_r;
  logic       sat_evt;

  always_ff @(posedge i_clk_sys) begin
    if (rst_int) begin
      ctrl_r <= CTRL_RST;
      rate_r <= RATE_RST;
    end else if (wr_p && cmd_r == CMD_CONTROL) begin
      ctrl_r <= wdat_r;
    end else if (wr_p && cmd_r == CMD_RATE) begin
      rate_r <= (wdat_r[3:0] > RATE_MAX) ? RATE_MAX : wdat_r[3:0];
    end
  end

  // A saturation in the same cycle as the clearing write keeps the flag set.
  always_ff @(posedge i_clk_sys) begin
    if (rst_int) begin
      sat_flag_r <= 1'b0;
    end else if (sat_evt) begin
      sat_flag_r <= 1'b1;
    end else if (wr_p && cmd_r == CMD_CONTROL && !wdat_r[SAT_BIT]) begin
      sat_flag_r <= 1'b0;
    end
  end

  assign o_saturation_flag = sat_flag_r;

  // ----------------------------------------------------------------
  // Rate divider
  // ----------------------------------------------------------------
  logic [31:0] div_cnt_r;
  logic [31:0] per_lim;
  logic        tick;
  logic        samp_pend_r;
  logic        upd_pend_r;
  logic        snap_p;
  logic        seq_go;

  assign per_lim = 32'(P_BASE_DIV) >> rate_r;
  assign tick    = (div_cnt_r >= per_lim - 32'h1);

  always_ff @(posedge i_clk_sys) begin
    if (rst_int || tick) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (rst_int) begin
      samp_pend_r <= 1'b0;
      upd_pend_r  <= 1'b0;
    end else begin
      samp_pend_r <= tick | (samp_pend_r & ~seq_go);
      upd_pend_r  <= upd_p | (upd_pend_r & ~snap_p);
    end
  end

  // ----------------------------------------------------------------
  // Measurement sequencer
  // ----------------------------------------------------------------
  dpa_seq_e                 q_r;
  dpa_kind_e                kind_r;
  logic                     ch_r;
  logic [VOLT_W-1:0]        volt_r [2];
  logic [ADC_I_W-1:0]       hi_r;
  logic [ADC_I_W-1:0]       lo_r;
  logic [CUR_W-1:0]         cur;
  logic [PROD_W-1:0]        product;
  logic [CNT_W-1:0]         acc_cnt_r;
  logic [CNT_W-1:0]         cnt_hold_r;
  logic [ACC_W-1:0]         hold_r [2];

  dpa_acc_if acc0 ();
  dpa_acc_if acc1 ();

  // Snapshot is only taken while idle, so an in-flight sample finishes first.
  assign snap_p      = (q_r == Q_IDLE) & upd_pend_r;
  assign seq_go      = (q_r == Q_IDLE) & ~upd_pend_r & samp_pend_r;
  assign o_adc_start = (q_r == Q_CONV);
  assign o_adc_chan  = ch_r;
  assign o_adc_kind  = kind_r;

  always_comb begin
    if (hi_r != HG_FULL) begin
      cur = CUR_W'(hi_r);
    end else begin
      cur = CUR_W'(lo_r) << GAIN_SHIFT;
    end
  end

  assign product = PROD_W'(cur) * PROD_W'(volt_r[ch_r]);

  always_ff @(posedge i_clk_sys) begin
    if (rst_int) begin
      q_r    <= Q_IDLE;
      kind_r <= KIND_VOLT;
      ch_r   <= 1'b0;
    end else begin
      unique case (q_r)
        Q_IDLE: begin
          if (seq_go) begin
            ch_r   <= 1'b0;
            kind_r <= KIND_VOLT;
            q_r    <= Q_CONV;
          end
        end
        Q_CONV: q_r <= Q_WAIT;
        Q_WAIT: begin
          if (i_adc_done) begin
            unique case (kind_r)
              KIND_VOLT: begin
                kind_r <= KIND_HI;
                q_r    <= Q_CONV;
              end
              KIND_HI: begin
                kind_r <= KIND_LO;
                q_r    <= Q_CONV;
              end
              KIND_LO: q_r <= Q_ADD;
            endcase
          end
        end
        Q_ADD: begin
          if (ch_r) begin
            q_r <= Q_IDLE;
          end else begin
            ch_r   <= 1'b1;
            kind_r <= KIND_VOLT;
            q_r    <= Q_CONV;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (rst_int) begin
      volt_r[0] <= '0;
      volt_r[1] <= '0;
      hi_r      <= '0;
      lo_r      <= '0;
    end else if (q_r == Q_WAIT && i_adc_done) begin
      unique case (kind_r)
        KIND_VOLT: volt_r[ch_r] <= i_adc_data;
        KIND_HI:   hi_r <= i_adc_data[ADC_I_W-1:0];
        KIND_LO:   lo_r <= i_adc_data[ADC_I_W-1:0];
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (rst_int) begin
      acc_cnt_r  <= '0;
      cnt_hold_r <= '0;
      hold_r[0]  <= '0;
      hold_r[1]  <= '0;
    end else if (snap_p) begin
      cnt_hold_r <= acc_cnt_r;
      hold_r[0]  <= acc0.acc;
      hold_r[1]  <= acc1.acc;
      acc_cnt_r  <= '0;
    end else if (q_r == Q_ADD && ch_r && !(&acc_cnt_r)) begin
      acc_cnt_r <= acc_cnt_r + CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Channel accumulators
  // ----------------------------------------------------------------
  assign acc0.add     = (q_r == Q_ADD) & ~ch_r;
  assign acc1.add     = (q_r == Q_ADD) & ch_r;
  assign acc0.clear   = snap_p;
  assign acc1.clear   = snap_p;
  assign acc0.product = product;
  assign acc1.product = product;
  assign sat_evt      = acc0.sat | acc1.sat;

  dpa_accum u_acc0 (
    .i_clk_sys (i_clk_sys),
    .i_rst     (rst_int),
    .bus       (acc0.acc_side)
  );

  dpa_accum u_acc1 (
    .i_clk_sys (i_clk_sys),
    .i_rst     (rst_int),
    .bus       (acc1.acc_side)
  );

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  logic [2:0] idx_r;
  logic [7:0] rd_byte;

  function automatic logic [7:0] pick(input logic [ACC_W-1:0] v, input logic [2:0] nb,
                                      input logic [2:0] ix);
    logic [2:0]       k;
    logic [ACC_W-1:0] sh;
    k    = nb - ix - 3'h1;
    sh   = v >> {k, 3'h0};
    pick = (ix >= nb) ? NO_DATA : sh[7:0];
  endfunction : pick

  always_comb begin
    unique case (cmd_r)
      CMD_CONTROL: rd_byte = (idx_r == 3'h0) ? {ctrl_r[7:1], sat_flag_r} : NO_DATA;
      CMD_ACC_CNT: rd_byte = pick(ACC_W'(cnt_hold_r), NB_CNT, idx_r);
      CMD_PWR_1:   rd_byte = pick(hold_r[0], NB_ACC, idx_r);
      CMD_PWR_2:   rd_byte = pick(hold_r[1], NB_ACC, idx_r);
      CMD_VOLT_1:  rd_byte = pick(ACC_W'(volt_r[0]), NB_VOLT, idx_r);
      CMD_VOLT_2:  rd_byte = pick(ACC_W'(volt_r[1]), NB_VOLT, idx_r);
      CMD_RATE:    rd_byte = (idx_r == 3'h0) ? {4'h0, rate_r} : NO_DATA;
      default:     rd_byte = NO_DATA;
    endcase
  end

  // ----------------------------------------------------------------
  // Serial bus target
  // ----------------------------------------------------------------
  dpa_bus_e   st_r;
  dpa_bus_e   ack_next_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] sh_r;
  logic [7:0] tx_r;
  logic       drive_low_r;
  logic       acked_r;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       byte_in;

  assign scl_rise = scl_s & ~scl_q_r;
  assign scl_fall = ~scl_s & scl_q_r;
  assign start_c  = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop_c   = scl_s & scl_q_r & ~sda_q_r & sda_s;
  assign byte_in  = (bit_cnt_r == BITS_BYTE);
  assign o_sda_o  = 1'b0;
  assign o_sda_oe = drive_low_r;

  always_ff @(posedge i_clk_sys) begin
    if (rst_int) begin
      st_r        <= T_IDLE;
      ack_next_r  <= T_SKIP;
      bit_cnt_r   <= 4'h0;
      sh_r        <= 8'h00;
      tx_r        <= 8'h00;
      drive_low_r <= 1'b0;
      acked_r     <= 1'b0;
      idx_r       <= 3'h0;
      cmd_r       <= CMD_RST;
      wdat_r      <= 8'h00;
      wr_p        <= 1'b0;
      upd_p       <= 1'b0;
    end else begin
      wr_p  <= 1'b0;
      upd_p <= 1'b0;
      if (start_c) begin
        st_r        <= T_ADDR;
        bit_cnt_r   <= 4'h0;
        drive_low_r <= 1'b0;
      end else if (stop_c) begin
        st_r        <= T_IDLE;
        drive_low_r <= 1'b0;
      end else if (scl_rise) begin
        unique case (st_r)
          T_ADDR, T_CMD, T_WDAT: begin
            sh_r      <= {sh_r[6:0], sda_s};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          T_RDAT: bit_cnt_r <= bit_cnt_r + 4'h1;
          T_RACK: acked_r <= ~sda_s;
          T_IDLE, T_ACK, T_SKIP: ;
        endcase
      end else if (scl_fall) begin
        unique case (st_r)
          T_ADDR: begin
            if (byte_in) begin
              bit_cnt_r <= 4'h0;
              idx_r     <= 3'h0;
              if (sh_r[7:1] == addr_r) begin
                st_r        <= T_ACK;
                drive_low_r <= 1'b1;
                ack_next_r  <= sh_r[0] ? T_RDAT : T_CMD;
              end else begin
                st_r <= T_SKIP;
              end
            end
          end
          T_CMD: begin
            if (byte_in) begin
              cmd_r       <= sh_r;
              upd_p       <= (sh_r == CMD_UPDATE);
              st_r        <= T_ACK;
              drive_low_r <= 1'b1;
              ack_next_r  <= T_WDAT;
            end
          end
          T_WDAT: begin
            if (byte_in) begin
              wdat_r      <= sh_r;
              wr_p        <= 1'b1;
              st_r        <= T_ACK;
              drive_low_r <= 1'b1;
              ack_next_r  <= T_SKIP;
            end
          end
          T_ACK: begin
            bit_cnt_r <= 4'h0;
            if (ack_next_r == T_RDAT) begin
              tx_r        <= rd_byte;
              drive_low_r <= ~rd_byte[7];
              st_r        <= T_RDAT;
            end else begin
              drive_low_r <= 1'b0;
              st_r        <= ack_next_r;
            end
          end
          T_RDAT: begin
            if (byte_in) begin
              drive_low_r <= 1'b0;
              st_r        <= T_RACK;
              idx_r       <= (idx_r == 3'h7) ? idx_r : idx_r + 3'h1;
            end else begin
              tx_r        <= {tx_r[6:0], 1'b0};
              drive_low_r <= ~tx_r[6];
            end
          end
          T_RACK: begin
            bit_cnt_r <= 4'h0;
            if (acked_r) begin
              tx_r        <= rd_byte;
              drive_low_r <= ~rd_byte[7];
              st_r        <= T_RDAT;
            end else begin
              st_r <= T_SKIP;
            end
          end
          T_IDLE, T_SKIP: ;
        endcase
      end
    end
  end
endmodule : dpa_top

// ### verif/dpa_checker.sv
// Concurrent checks on the pins of the dual power accumulator.
`timescale 1ns/1ps
module dpa_checker
  import dpa_pkg::*;
(
  input wire logic              i_clk_sys,
  input wire logic              i_rst,
  input wire logic              i_scl,
  input wire logic              i_sda,
  input wire logic              o_sda_o,
  input wire logic              o_sda_oe,
  input wire logic              i_addr_rst_pin,
  input wire logic [6:0]        i_addr_code,
  input wire logic              o_adc_start,
  input wire logic              o_adc_chan,
  input wire dpa_kind_e         o_adc_kind,
  input wire logic              i_adc_done,
  input wire logic [VOLT_W-1:0] i_adc_data,
  input wire logic              o_saturation_flag
);
  logic       busy_r;
  logic       last_chan_r;
  dpa_kind_e  last_kind_r;
  logic [3:0] since_lo_r;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // ----------------------------------------------------------------
  // Tracking of conversion requests
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || i_adc_done) busy_r <= 1'b0;
    else if (o_adc_start) busy_r <= 1'b1;
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      last_kind_r <= KIND_LO;
      last_chan_r <= 1'b1;
    end else if (o_adc_start) begin
      last_kind_r <= o_adc_kind;
      last_chan_r <= o_adc_chan;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) since_lo_r <= 4'hf;
    else if (i_adc_done && o_adc_kind == KIND_LO) since_lo_r <= 4'h0;
    else if (since_lo_r != 4'hf) since_lo_r <= since_lo_r + 4'h1;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_rst;
    disable iff (1'b0) i_rst |=> !o_sda_oe && !o_adc_start && !o_saturation_flag
      && o_adc_kind == KIND_VOLT && !o_adc_chan;
  endproperty
  property p_od;
    o_sda_o == 1'b0;
  endproperty
  property p_pulse;
    o_adc_start |=> !o_adc_start;
  endproperty
  property p_order;
    o_adc_start |-> (o_adc_kind == KIND_VOLT) ? (last_kind_r == KIND_LO
      && o_adc_chan != last_chan_r) : (o_adc_chan == last_chan_r
      && ((o_adc_kind == KIND_HI && last_kind_r == KIND_VOLT)
      || (o_adc_kind == KIND_LO && last_kind_r == KIND_HI)));
  endproperty
  property p_wait;
    o_adc_start |-> !busy_r;
  endproperty
  property p_hold;
    busy_r |-> $stable(o_adc_chan) && $stable(o_adc_kind);
  endproperty
  property p_sticky;
    o_saturation_flag && !o_sda_oe && !i_addr_rst_pin |=> o_saturation_flag;
  endproperty
  property p_flag_src;
    $rose(o_saturation_flag) |-> since_lo_r < 4'h5;
  endproperty
  property p_stop;
    i_scl && $rose(i_sda) |=> !o_sda_oe [*8];
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  a_od: assert property (p_od) else $error("data pin driven high");
  a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
  a_order: assert property (p_order) else $error("conversion order wrong");
  a_wait: assert property (p_wait) else $error("start while busy");
  a_hold: assert property (p_hold) else $error("channel moved mid conversion");
  a_sticky: assert property (p_sticky) else $error("flag dropped");
  a_flag_src: assert property (p_flag_src) else $error("flag rose off an add");
  a_stop: assert property (p_stop) else $error("data driven after stop");
  c_lo: cover property (o_adc_start && o_adc_kind == KIND_LO && o_adc_chan);
  c_ack: cover property ($rose(o_sda_oe));
  c_stop: cover property (i_scl && $rose(i_sda));
endmodule : dpa_checker

bind dpa_top dpa_checker dpa_checker_inst (.i_clk_sys, .i_rst, .i_scl, .i_sda, .o_sda_o,
  .o_sda_oe, .i_addr_rst_pin, .i_addr_code, .o_adc_start, .o_adc_chan, .o_adc_kind,
  .i_adc_done, .i_adc_data, .o_saturation_flag);

// ### verif/dpa_host_model.sv
// Serial bus host model that frames transfers on the open-drain lines.
`timescale 1ns/1ps
module dpa_host_model #(
  parameter int P_WAIT_NS = 1_000_000
) (
  output logic      o_scl,
  output logic      o_sda_oe,
  input  wire logic i_sda
);
  // The clock line idles high and toggles only inside frames.
  initial begin
    o_scl    = 1'b1;
    o_sda_oe = 1'b0;
  end
  task automatic start;
    o_sda_oe = 1'b0;
    #100 o_scl = 1'b1;
    #50 o_sda_oe = 1'b1;
    #50 o_scl = 1'b0;
    #50;
  endtask : start
  task automatic stop;
    #50 o_sda_oe = 1'b1;
    #50 o_scl = 1'b1;
    #50 o_sda_oe = 1'b0;
    #50;
  endtask : stop
  // Nine bits, the last being the acknowledge slot; a one releases the line.
  task automatic xbyte(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      #50 o_sda_oe = ~d[i];
      #50 o_scl = 1'b1;
      #50 q[i] = i_sda;
      #50 o_scl = 1'b0;
    end
  endtask : xbyte
  task automatic hold_off;
    #P_WAIT_NS;
  endtask : hold_off
endmodule : dpa_host_model

// ### verif/dpa_top_bench.sv
// Self-checking bench of the dual power accumulator.
`timescale 1ns/1ps
module dpa_top_bench;
  import dpa_pkg::*;
  localparam int DIV = 1024;
  localparam int WIN = 4096;
  logic        clk = 1'b0, rst = 1'b1, pin = 1'b0, done = 1'b0;
  logic        scl, h_oe, d_oe, sda, chan, start, sflag;
  logic [6:0]  code = 7'h22, addr = 7'h22;
  logic [13:0] adata = '0;
  logic [13:0] av[2], ah[2], al[2];
  dpa_kind_e   kind;
  int          mismatches = 0, tests_run = 0;
  always #12.5 clk = ~clk;
  assign sda = !(h_oe || d_oe);
  dpa_host_model #(.P_WAIT_NS(20000)) dpa_host_model_inst (.o_scl(scl), .o_sda_oe(h_oe),
    .i_sda(sda));
  dpa_top #(.P_BASE_DIV(DIV)) dpa_top_inst (.i_clk_sys(clk), .i_rst(rst), .i_scl(scl),
    .i_sda(sda), .o_sda_o(), .o_sda_oe(d_oe), .i_addr_rst_pin(pin), .i_addr_code(code),
    .o_adc_start(start), .o_adc_chan(chan), .o_adc_kind(kind), .i_adc_done(done),
    .i_adc_data(adata), .o_saturation_flag(sflag));
  // Converter model; the second channel answers more slowly.
  // Done drops at the very negedge that looks for the next start, so no start is missed.
  always begin
    @(negedge clk);
    done = 1'b0;
    if (start === 1'b1) begin
      repeat (1 + 4 * chan) @(negedge clk);
      adata = (kind == KIND_VOLT) ? av[chan] : (kind == KIND_HI) ? ah[chan] : al[chan];
      done = 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [55:0] g, input logic [55:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic frame_w(input logic [7:0] cmd, input logic [7:0] dat, input bit nd);
    logic [8:0] q;
    dpa_host_model_inst.start();
    dpa_host_model_inst.xbyte({addr, 2'b01}, q);
    chk(q[0], 1'b0);
    dpa_host_model_inst.xbyte({cmd, 1'b1}, q);
    chk(q[0], 1'b0);
    if (nd) begin
      dpa_host_model_inst.xbyte({dat, 1'b1}, q);
      chk(q[0], 1'b0);
    end
    dpa_host_model_inst.stop();
  endtask : frame_w
  task automatic frame_r(input logic [7:0] cmd, input int n, output logic [55:0] v);
    logic [8:0] q;
    v = '0;
    frame_w(cmd, 8'h00, 1'b0);
    dpa_host_model_inst.start();
    dpa_host_model_inst.xbyte({addr, 2'b11}, q);
    chk(q[0], 1'b0);
    for (int i = n; i > 0; i--) begin
      dpa_host_model_inst.xbyte({8'hff, i == 1}, q);
      v = {v[47:0], q[8:1]};
    end
    dpa_host_model_inst.stop();
  endtask : frame_r
  task automatic upd;
    frame_w(CMD_UPDATE, 8'h00, 1'b0);
    dpa_host_model_inst.hold_off();
  endtask : upd
  task automatic count_span(input int d);
    logic [55:0] n;
    upd();
    repeat (WIN) @(negedge clk);
    upd();
    frame_r(CMD_ACC_CNT, 3, n);
    chk(n >= WIN / d && n <= (WIN + 1200) / d + 1, 1'b1);
  endtask : count_span
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_boot;
    logic [8:0]  q;
    logic [55:0] v;
    dpa_host_model_inst.start();
    dpa_host_model_inst.xbyte({addr, 2'b11}, q);
    chk(q[0], 1'b0);
    dpa_host_model_inst.xbyte(9'h1ff, q);
    chk(q[8:1], CTRL_RST);
    dpa_host_model_inst.start();
    dpa_host_model_inst.xbyte({7'h24, 2'b01}, q);
    chk(q[0], 1'b1);
    dpa_host_model_inst.stop();
    frame_r(8'h0f, 1, v);
    chk(v, NO_DATA);
    $display("t_boot done");
  endtask : t_boot
  task automatic t_accum;
    logic [55:0] n, v;
    upd();
    repeat (WIN) @(negedge clk);
    upd();
    frame_r(CMD_ACC_CNT, 3, n);
    chk(n >= WIN / DIV && n <= (WIN + 1200) / DIV + 1, 1'b1);
    frame_r(CMD_PWR_1, 7, v);
    chk(v, n * 56'h100000);
    frame_r(CMD_PWR_2, 7, v);
    chk(v, n * 56'h3000);
    frame_r(CMD_VOLT_1, 2, v);
    chk(v, 56'h1000);
    $display("t_accum done");
  endtask : t_accum
  task automatic t_rate;
    logic [55:0] v;
    frame_w(CMD_RATE, 8'h02, 1'b1);
    frame_r(CMD_RATE, 1, v);
    chk(v, 56'h2);
    count_span(DIV >> 2);
    chk(sflag, 1'b0);
    $display("t_rate done");
  endtask : t_rate
  task automatic t_pin;
    logic [55:0] v;
    frame_w(CMD_CONTROL, 8'h84, 1'b1);
    frame_r(CMD_CONTROL, 1, v);
    chk(v, 56'h84);
    for (int i = 0; i < 2000 && !(start === 1'b1 && chan === 1'b1 && kind == KIND_LO); i++)
      @(negedge clk);
    repeat (40) @(negedge clk);
    pin = 1'b1;
    repeat (10) @(negedge clk);
    addr = 7'h30;
    frame_r(CMD_CONTROL, 1, v);
    chk(v, 56'h0);
    frame_r(CMD_RATE, 1, v);
    chk(v, 56'h0);
    $display("t_pin done");
  endtask : t_pin
  task automatic tally_and_finish;
    $display("Checks run %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    av = '{14'h1000, 14'h0003};
    ah = '{14'h0100, 14'h1fff};
    al = '{14'h0002, 14'h0200};
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    code = 7'h30;
    t_boot();
    t_accum();
    t_rate();
    t_pin();
    tally_and_finish();
  end
  initial begin
    #1_500_000;
    mismatches++;
    tally_and_finish();
  end
endmodule : dpa_top_bench
